// ---- gain_trim_pkg.sv ----
// constants and carriers for the fine gain trim bank
// assumes a 32-bit avalon-mm register bus on a single 100 mhz clock
package gain_trim_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] off_core3_input_c = 12'h364;
  localparam logic [11:0] off_core3_input_d = 12'h365;
  localparam logic [11:0] off_core_four = 12'h366;
  localparam logic [11:0] off_core_five = 12'h367;
  localparam logic [11:0] off_trim_control = 12'h368;
  localparam logic [11:0] off_trim_status = 12'h36c;

  // ==========================================================
  // field layout
  localparam int gain_width = 5;
  localparam int reg_width = 8;
  localparam int reg_count = 4;
  localparam logic [7:0] gain_reset = 8'h00;
  localparam logic [31:0] unmapped_read = 32'h00000000;

  // register indices within the bank
  localparam logic [1:0] idx_core3_c = 2'h0;
  localparam logic [1:0] idx_core3_d = 2'h1;
  localparam logic [1:0] idx_core_four = 2'h2;
  localparam logic [1:0] idx_core_five = 2'h3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [11:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bus_req_s;

  typedef struct packed {
    logic [gain_width-1:0] core3;
    logic [gain_width-1:0] core_four;
    logic [gain_width-1:0] core_five;
  } gain_codes_s;

  typedef enum logic [1:0] {
    fuse_idle,
    fuse_wait,
    fuse_done
  } fuse_state_e;

endpackage

// ---- trim_byte_reg.sv ----
// one byte-wide trim register with a load path from the fuse store
// assumes write strobes are already decoded by the bank
`timescale 1ns/1ps

module trim_byte_reg (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_enable,
  input wire logic bus_write,
  input wire logic [7:0] bus_data,
  input wire logic fuse_load,
  input wire logic [gain_trim_pkg::gain_width-1:0] fuse_code,
  output logic [7:0] value
);

  logic [7:0] value_reg;
  logic [7:0] value_next;

  // ==========================================================
  // next value
  always_comb begin
    value_next = value_reg;
    // fuse load wins over a bus write in the same cycle; later writes may override it
    if (fuse_load) begin
      value_next = {3'h0, fuse_code};
    end else if (bus_write) begin
      // reserved upper bits stored as written
      value_next = bus_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= gain_trim_pkg::gain_reset;
    end else if (clock_enable) begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

// ---- input_pair_select.sv ----
// chooses the core 3 code for the input pair being sampled
// assumes the selection level is already synchronised to clock
`timescale 1ns/1ps

module input_pair_select (
  input wire logic sample_fourth_pair,
  input wire logic [gain_trim_pkg::gain_width-1:0] code_c,
  input wire logic [gain_trim_pkg::gain_width-1:0] code_d,
  output logic [gain_trim_pkg::gain_width-1:0] code_out
);

  // ==========================================================
  // route selected code
  always_comb begin
    code_out = sample_fourth_pair ? code_d : code_c;
  end

endmodule

// ---- fine_gain_trim_bank.sv ----
// fine gain trim bank for converter cores three to five
// assumes an avalon-mm master and a fuse store that answers with a ready pulse
`timescale 1ns/1ps

module fine_gain_trim_bank (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_enable,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic fourth_input_pair_sel,
  output logic fuse_request,
  input wire logic fuse_ready,
  input wire logic [19:0] fuse_codes,
  output logic [4:0] converter_core_three_gain,
  output logic [4:0] converter_core_four_gain,
  output logic [4:0] converter_core_five_gain,
  output logic fuse_loaded
);

  localparam int gw = gain_trim_pkg::gain_width;

  gain_trim_pkg::bus_req_s req;
  gain_trim_pkg::gain_codes_s codes_next;
  gain_trim_pkg::gain_codes_s codes_reg;
  gain_trim_pkg::fuse_state_e fuse_state_reg;
  gain_trim_pkg::fuse_state_e fuse_state_next;
  logic [7:0] reg_value [gain_trim_pkg::reg_count];
  logic [gain_trim_pkg::reg_count-1:0] reg_write;
  logic [gain_trim_pkg::reg_count-1:0] reg_hit;
  logic fuse_load;
  logic fuse_request_reg;
  logic fuse_request_next;
  logic fuse_loaded_reg;
  logic fuse_loaded_next;
  logic sel_meta_reg;
  logic sel_sync_reg;
  logic fuse_ready_meta_reg;
  logic fuse_ready_sync_reg;
  logic reload_pulse;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic wait_reg;
  logic wait_next;
  logic [4:0] core3_code;

  assign req.address = avs_address;
  assign req.read = avs_read;
  assign req.write = avs_write;
  assign req.writedata = avs_writedata;
  assign req.byteenable = avs_byteenable;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_meta_reg <= 1'b0;
      sel_sync_reg <= 1'b0;
      fuse_ready_meta_reg <= 1'b0;
      fuse_ready_sync_reg <= 1'b0;
    end else if (clock_enable) begin
      sel_meta_reg <= fourth_input_pair_sel;
      sel_sync_reg <= sel_meta_reg;
      fuse_ready_meta_reg <= fuse_ready;
      fuse_ready_sync_reg <= fuse_ready_meta_reg;
    end
  end

  // ==========================================================
  // fuse load sequence
  // fuse codes must be steady while fuse_ready is high
  always_comb begin
    fuse_state_next = fuse_state_reg;
    fuse_request_next = fuse_request_reg;
    fuse_loaded_next = fuse_loaded_reg;
    fuse_load = 1'b0;
    unique case (fuse_state_reg)
      gain_trim_pkg::fuse_idle: begin
        fuse_request_next = 1'b1;
        fuse_state_next = gain_trim_pkg::fuse_wait;
      end
      gain_trim_pkg::fuse_wait: begin
        if (fuse_ready_sync_reg) begin
          fuse_load = 1'b1;
          fuse_request_next = 1'b0;
          fuse_loaded_next = 1'b1;
          fuse_state_next = gain_trim_pkg::fuse_done;
        end
      end
      gain_trim_pkg::fuse_done: begin
        if (reload_pulse) begin
          fuse_loaded_next = 1'b0;
          fuse_state_next = gain_trim_pkg::fuse_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fuse_state_reg <= gain_trim_pkg::fuse_idle;
      fuse_request_reg <= 1'b0;
      fuse_loaded_reg <= 1'b0;
    end else if (clock_enable) begin
      fuse_state_reg <= fuse_state_next;
      fuse_request_reg <= fuse_request_next;
      fuse_loaded_reg <= fuse_loaded_next;
    end
  end

  // ==========================================================
  // address decode
  always_comb begin
    reg_hit = '0;
    unique case (req.address)
      gain_trim_pkg::off_core3_input_c: reg_hit[gain_trim_pkg::idx_core3_c] = 1'b1;
      gain_trim_pkg::off_core3_input_d: reg_hit[gain_trim_pkg::idx_core3_d] = 1'b1;
      gain_trim_pkg::off_core_four: reg_hit[gain_trim_pkg::idx_core_four] = 1'b1;
      gain_trim_pkg::off_core_five: reg_hit[gain_trim_pkg::idx_core_five] = 1'b1;
      default: reg_hit = '0;
    endcase
  end

  // writes land only on the accepting cycle, when waitrequest is low
  assign reload_pulse = req.write && !wait_reg && req.byteenable[0]
    && (req.address == gain_trim_pkg::off_trim_control) && req.writedata[0];

  // ==========================================================
  // trim registers
  genvar gi;
  generate
    for (gi = 0; gi < gain_trim_pkg::reg_count; gi = gi + 1) begin : g_trim
      assign reg_write[gi] = req.write && !wait_reg && reg_hit[gi] && req.byteenable[0];
      trim_byte_reg u_trim (
        .clock(clock),
        .rst_n(rst_n),
        .clock_enable(clock_enable),
        .bus_write(reg_write[gi]),
        .bus_data(req.writedata[7:0]),
        .fuse_load(fuse_load),
        .fuse_code(fuse_codes[gi*gw +: gw]),
        .value(reg_value[gi])
      );
    end
  endgenerate

  // ==========================================================
  // bus answer: one wait cycle, then accept
  always_comb begin
    wait_next = 1'b1;
    readdata_next = readdata_reg;
    if ((req.read || req.write) && wait_reg) begin
      wait_next = 1'b0;
      readdata_next = gain_trim_pkg::unmapped_read;
      if (req.read) begin
        for (int i = 0; i < gain_trim_pkg::reg_count; i++) begin
          if (reg_hit[i]) begin
            readdata_next = {24'h000000, reg_value[i]};
          end
        end
        if (req.address == gain_trim_pkg::off_trim_status) begin
          readdata_next = {31'h00000000, fuse_loaded_reg};
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      readdata_reg <= gain_trim_pkg::unmapped_read;
    end else if (clock_enable) begin
      wait_reg <= wait_next;
      readdata_reg <= readdata_next;
    end
  end

  // ==========================================================
  // gain outputs
  input_pair_select u_select (
    .sample_fourth_pair(sel_sync_reg),
    .code_c(reg_value[gain_trim_pkg::idx_core3_c][gw-1:0]),
    .code_d(reg_value[gain_trim_pkg::idx_core3_d][gw-1:0]),
    .code_out(core3_code)
  );

  always_comb begin
    codes_next.core3 = core3_code;
    codes_next.core_four = reg_value[gain_trim_pkg::idx_core_four][gw-1:0];
    codes_next.core_five = reg_value[gain_trim_pkg::idx_core_five][gw-1:0];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      codes_reg <= '0;
    end else if (clock_enable) begin
      codes_reg <= codes_next;
    end
  end

  assign converter_core_three_gain = codes_reg.core3;
  assign converter_core_four_gain = codes_reg.core_four;
  assign converter_core_five_gain = codes_reg.core_five;
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = wait_reg;
  assign fuse_request = fuse_request_reg;
  assign fuse_loaded = fuse_loaded_reg;

endmodule

// ---- fine_gain_trim_bank_checker.sv ----
// assertions on the trim bank ports
// assumes a bind onto fine_gain_trim_bank
`timescale 1ns/1ps
module gain_trim_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_enable,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic fuse_request,
  input wire logic [19:0] fuse_codes,
  input wire logic [4:0] converter_core_four_gain,
  input wire logic [4:0] converter_core_five_gain,
  input wire logic fuse_loaded
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_ok = avs_read && !avs_waitrequest;
  // ==========================================================
  // bus answers
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest && clock_enable
    |=> !avs_waitrequest) else $error("bus answer late");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  a_unmapped_zero: assert property (rd_ok && avs_address[11:4] != 8'h36
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_upper_zero: assert property (rd_ok |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
  // ==========================================================
  // fuse defaults and gain outputs
  a_fuse_excl: assert property (fuse_loaded |-> !fuse_request) else $error("request after load");
  a_fuse_after_req: assert property ($rose(fuse_loaded) |-> $past(fuse_request)) else $error("no request");
  a_fuse_codes: assert property ($rose(fuse_loaded) |=> converter_core_four_gain == fuse_codes[14:10]
    && converter_core_five_gain == fuse_codes[19:15]) else $error("fuse codes not applied");
  a_core_four: assert property (wr_ok && avs_address == gain_trim_pkg::off_core_four
    |-> ##2 converter_core_four_gain == $past(avs_writedata[4:0], 2)) else $error("core four gain");
  a_core_five: assert property (wr_ok && avs_address == gain_trim_pkg::off_core_five
    |-> ##2 converter_core_five_gain == $past(avs_writedata[4:0], 2)) else $error("core five gain");
  cover property (wr_ok);
  cover property (rd_ok && avs_address[11:4] != 8'h36);
  cover property ($rose(fuse_loaded));
endmodule

// ---- fine_gain_trim_bank_tb.sv ----
// self-checking bench for the trim bank
// assumes the package, design and checker are compiled first
`timescale 1ns/1ps
module fine_gain_trim_bank_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clock_enable = 1'b1;
  logic [11:0] avs_address = 12'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic fourth_input_pair_sel = 1'b0;
  logic fuse_request;
  logic fuse_ready = 1'b0;
  logic [19:0] fuse_codes = 20'h0;
  logic [4:0] converter_core_three_gain;
  logic [4:0] converter_core_four_gain;
  logic [4:0] converter_core_five_gain;
  logic fuse_loaded;
  logic [31:0] seed = 32'h6cd17a9e;
  logic [31:0] q;
  logic [31:0] v;
  logic [7:0] exp_reg [4];
  int errors = 0;
  int comparisons = 0;
  always #5 clock = ~clock;
  fine_gain_trim_bank dut (.clock, .rst_n, .clock_enable, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .fourth_input_pair_sel,
    .fuse_request, .fuse_ready, .fuse_codes, .converter_core_three_gain,
    .converter_core_four_gain, .converter_core_five_gain, .fuse_loaded);
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // core3 follows the code of the pair being sampled
  function automatic logic [31:0] core3_exp(input logic sel);
    return {27'h0, sel ? exp_reg[1][4:0] : exp_reg[0][4:0]};
  endfunction
  task test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clock);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task check_all;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 12'h364 + 12'(i), 8'h0, 4'h1);
      check("trim_reg", q, {24'h0, exp_reg[i]});
    end
    // select pin needs three edges through its synchroniser
    repeat (4) @(posedge clock);
    check("core3", {27'h0, converter_core_three_gain}, core3_exp(fourth_input_pair_sel));
    check("core4", {27'h0, converter_core_four_gain}, {27'h0, exp_reg[2][4:0]});
    check("core5", {27'h0, converter_core_five_gain}, {27'h0, exp_reg[3][4:0]});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    while (fuse_request !== 1'b1) @(posedge clock);
    fuse_codes <= 20'(rnd());
    fuse_ready <= 1'b1;
    while (fuse_loaded !== 1'b1) @(posedge clock);
    for (int i = 0; i < 4; i++) exp_reg[i] = {3'h0, fuse_codes[5*i +: 5]};
    check("fuse_request", {31'h0, fuse_request}, 32'h0);
    check_all;
    fuse_ready <= 1'b0;
    for (int k = 0; k < 24; k++) begin
      v = rnd();
      if (k == 0) v[8:4] = 5'h1f;
      // reserved bits always written as zero
      bus(1'b1, 12'h364 + {10'h0, v[1:0]}, {3'h0, v[8:4]}, 4'h1);
      exp_reg[v[1:0]] = {3'h0, v[8:4]};
      fourth_input_pair_sel <= v[12];
      if (k % 6 == 5) check_all;
    end
    // lane 0 disabled and unmapped writes must change nothing
    bus(1'b1, 12'h366, 8'h15, 4'he);
    bus(1'b1, 12'h3a0, 8'h0a, 4'h1);
    bus(1'b0, 12'h3a0, 8'h0, 4'h1);
    check("unmapped", q, 32'h0);
    check_all;
    // reload: status drops, request returns, fresh defaults land
    bus(1'b0, 12'h36c, 8'h0, 4'h1);
    check("status", q, 32'h1);
    bus(1'b1, 12'h368, 8'h01, 4'h1);
    bus(1'b0, 12'h36c, 8'h0, 4'h1);
    check("status", q, 32'h0);
    while (fuse_request !== 1'b1) @(posedge clock);
    fuse_codes <= 20'(rnd());
    fuse_ready <= 1'b1;
    while (fuse_loaded !== 1'b1) @(posedge clock);
    fuse_ready <= 1'b0;
    for (int j = 0; j < 4; j++) exp_reg[j] = {3'h0, fuse_codes[5*j +: 5]};
    check_all;
    test_done;
  end
  initial begin
    #50000;
    errors++;
    test_done;
  end
endmodule
bind fine_gain_trim_bank gain_trim_checker u_chk (.clock(clock), .rst_n(rst_n),
  .clock_enable(clock_enable), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .fuse_request(fuse_request), .fuse_codes(fuse_codes),
  .converter_core_four_gain(converter_core_four_gain),
  .converter_core_five_gain(converter_core_five_gain), .fuse_loaded(fuse_loaded));
